// file: verilog/bmb_proc_end.sv
// processor end of the backplane module bus
// assumes modules share clk; every bus input still passes a 3-flop agreeing filter
//
// What this block does
// - processor drives address; 8-bit uses sixteen lines
// - grant only after bus and strobes released
// - requester pulls request low, waits for grant
// - data bidirectional; 8-bit uses low byte only
// - shared interrupt pulled low, never driven high
// - no fetch indicator: leave fetch line pulled up
// - memory cycle only while address is valid
// - unmaskable interrupt taken on falling edge
// - boot ROM at zero until page goes high; module decodes it only with all 24 lines driven (PROF_80, wide_addr)
// - separate read and write strobes, active low
// - stretch cycle while not-ready stays low
// - refresh line low during refresh cycles
// - serial port drives transmit, terminal drives receive
// - DMA grant passes down the chain
// - chain-in high means no higher interrupter
// - chain-out high only when in high, idle
// - alternate family: read/write line, enable, fast irq
// - serial-I/O family: serial clock, memory enable
// - legacy bus clock is 7.3728 MHz
// - over four chained modules needs lookahead logic
// - minimal profile: eight address, eight data lines
// - drive only supported upper address lines
`timescale 1ns/100ps
`default_nettype none
`include "bmb_cfg.svh"

module bmb_proc_end (
	input wire logic clk,
	input wire logic rst,
	bmb_bus_if.proc bus,
	input wire bmb_pkg::bmb_family_t family,
	input wire bmb_pkg::bmb_profile_t profile,
	input wire logic wide_addr,
	input wire logic has_fetch_indicator,
	input wire logic page_sel,
	input wire logic halt_req,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire bmb_pkg::bmb_cmd_t cmd_kind,
	input wire logic cmd_fetch,
	input wire logic cmd_wide,
	input wire logic [`BMB_ADDR_W-1:0] cmd_addr,
	input wire logic [`BMB_DATA_W-1:0] cmd_wdata,
	output logic rsp_valid,
	output logic [`BMB_DATA_W-1:0] rsp_rdata,
	output logic bus_released,
	output logic irq_level,
	output logic fast_irq,
	output logic nmi_pending,
	input wire logic nmi_ack,
	input wire logic tx_in,
	output logic rx_out
);

	// ---------------------------------------------------------------
	// input filter
	// ---------------------------------------------------------------
	logic [`BMB_PSYNC_W-1:0] sync1_reg;
	logic [`BMB_PSYNC_W-1:0] sync2_reg;
	logic [`BMB_PSYNC_W-1:0] sync3_reg;
	logic [`BMB_PSYNC_W-1:0] in_reg;
	logic [`BMB_PSYNC_W-1:0] pins;
	logic busrq_s, irq_s, nmi_s, firq_s, wait_s, de_s, sio_s, rx_s;
	logic [`BMB_DATA_W-1:0] data_s;

	assign pins = {bus.not_ready_n, bus.master_request_n, bus.shared_irq_n,
		bus.unmaskable_irq_n, bus.fast_irq_n, bus.data_enable, bus.serial_io_in,
		bus.rx, bus.data};

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			sync3_reg <= '1;
			in_reg <= '1;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			in_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (in_reg & (sync2_reg ^ sync3_reg));
		end
	end

	assign {wait_s, busrq_s, irq_s, nmi_s, firq_s, de_s, sio_s, rx_s, data_s} = in_reg;

	// ---------------------------------------------------------------
	// cycle sequencer
	// ---------------------------------------------------------------
	bmb_pkg::bmb_state_t state_reg;
	bmb_pkg::bmb_state_t state_next;
	logic [`BMB_CNT_W-1:0] cnt_reg;
	bmb_pkg::bmb_cmd_t kind_reg;
	logic fetch_reg;
	logic wide_reg;
	logic [`BMB_ADDR_W-1:0] addr_reg;
	logic [`BMB_DATA_W-1:0] wdata_reg;
	logic stretch;

	// the alternate family holds the cycle until its data enable rises
	assign stretch = !wait_s || (family == bmb_pkg::FAM_ALT && !de_s);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bmb_pkg::ST_IDLE: begin
				if (!busrq_s) begin
					state_next = bmb_pkg::ST_RELEASE;
				end else if (cmd_valid) begin
					state_next = bmb_pkg::ST_ADDR;
				end
			end
			bmb_pkg::ST_ADDR: state_next = bmb_pkg::ST_STROBE;
			bmb_pkg::ST_STROBE: begin
				if (cnt_reg == '0) begin
					state_next = bmb_pkg::ST_WAIT;
				end
			end
			bmb_pkg::ST_WAIT: begin
				if (!stretch) begin
					state_next = bmb_pkg::ST_DONE;
				end
			end
			bmb_pkg::ST_DONE: state_next = bmb_pkg::ST_IDLE;
			// one cycle with everything released before the grant goes low
			bmb_pkg::ST_RELEASE: state_next = bmb_pkg::ST_GRANT;
			bmb_pkg::ST_GRANT: begin
				if (busrq_s) begin
					state_next = bmb_pkg::ST_IDLE;
				end
			end
			default: state_next = bmb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= bmb_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (state_reg == bmb_pkg::ST_ADDR) begin
			cnt_reg <= `BMB_CNT_W'(`BMB_STROBE_CYC - 1);
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			kind_reg <= bmb_pkg::CMD_MEM_RD;
			fetch_reg <= 1'b0;
			wide_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (cmd_valid && cmd_ready) begin
			kind_reg <= cmd_kind;
			fetch_reg <= cmd_fetch;
			wide_reg <= cmd_wide;
			addr_reg <= cmd_addr;
			wdata_reg <= cmd_wdata;
		end
	end

	assign cmd_ready = state_reg == bmb_pkg::ST_IDLE && busrq_s;

	// ---------------------------------------------------------------
	// read data and answer
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_rdata <= '0;
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= state_next == bmb_pkg::ST_DONE && state_reg == bmb_pkg::ST_WAIT;
			if (state_reg == bmb_pkg::ST_WAIT && !stretch) begin
				if (kind_reg == bmb_pkg::CMD_SIO) begin
					rsp_rdata <= {{(`BMB_DATA_W-1){1'b0}}, sio_s};
				end else if (wide_reg && profile >= bmb_pkg::PROF_ENH) begin
					rsp_rdata <= data_s;
				end else begin
					rsp_rdata <= {8'h00, data_s[`BMB_LOW_BYTE_MSB:0]};
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------
	logic owned, active, strobing, is_mem, is_io, is_rd, is_wr;

	assign owned = state_reg != bmb_pkg::ST_RELEASE && state_reg != bmb_pkg::ST_GRANT;
	assign active = state_reg == bmb_pkg::ST_ADDR || strobing;
	assign strobing = state_reg == bmb_pkg::ST_STROBE || state_reg == bmb_pkg::ST_WAIT;
	assign is_mem = kind_reg == bmb_pkg::CMD_MEM_RD || kind_reg == bmb_pkg::CMD_MEM_WR
		|| kind_reg == bmb_pkg::CMD_REFRESH;
	assign is_io = kind_reg == bmb_pkg::CMD_IO_RD || kind_reg == bmb_pkg::CMD_IO_WR;
	assign is_rd = kind_reg == bmb_pkg::CMD_MEM_RD || kind_reg == bmb_pkg::CMD_IO_RD;
	assign is_wr = kind_reg == bmb_pkg::CMD_MEM_WR || kind_reg == bmb_pkg::CMD_IO_WR;

	assign bus.p_addr = addr_reg;
	always_comb begin
		bus.p_addr_oe_n = '1;
		if (owned) begin
			bus.p_addr_oe_n[`BMB_LOW_BYTE_MSB:0] = '0;
			if (profile != bmb_pkg::PROF_MINIMAL) begin
				bus.p_addr_oe_n[`BMB_WORD16_MSB:`BMB_LOW_BYTE_MSB+1] = '0;
			end
			// upper lines float to their pull-ups unless this processor uses them
			if (profile == bmb_pkg::PROF_80 && wide_addr) begin
				bus.p_addr_oe_n[`BMB_ADDR_W-1:`BMB_WORD16_MSB+1] = '0;
			end
		end
	end

	assign bus.p_data = wdata_reg;
	assign bus.p_data_oe_n[0] = !(owned && active && is_wr);
	assign bus.p_data_oe_n[1] = !(owned && active && is_wr && wide_reg
		&& profile >= bmb_pkg::PROF_ENH);

	assign bus.p_ctl_oe_n = !owned;
	always_comb begin
		bus.p_ctl_n = `BMB_IDLE_CTL;
		bus.p_ctl_n[`BMB_CTL_MEM] = !(active && is_mem);
		bus.p_ctl_n[`BMB_CTL_IO] = !(active && is_io);
		bus.p_ctl_n[`BMB_CTL_RD] = !(strobing && is_rd);
		bus.p_ctl_n[`BMB_CTL_WR] = !(strobing && is_wr);
	end

	assign bus.p_fetch_oe_n = !(owned && has_fetch_indicator);
	assign bus.p_fetch_n = !(active && fetch_reg && kind_reg == bmb_pkg::CMD_MEM_RD);
	assign bus.refresh_cycle_n = !(active && kind_reg == bmb_pkg::CMD_REFRESH);
	assign bus.bus_grant_n = state_reg != bmb_pkg::ST_GRANT;
	assign bus_released = state_reg == bmb_pkg::ST_GRANT;

	assign bus.read_write = !(family == bmb_pkg::FAM_ALT && active && is_wr);
	assign bus.memory_enable_n = !(family == bmb_pkg::FAM_SIO && active && is_mem);
	assign bus.serial_io_clock_n = !(family == bmb_pkg::FAM_SIO && strobing
		&& kind_reg == bmb_pkg::CMD_SIO);

	// ---------------------------------------------------------------
	// side lines and interrupts
	// ---------------------------------------------------------------
	logic nmi_prev_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			bus.halted_n <= 1'b1;
			bus.page <= 1'b0;
			bus.tx <= 1'b1;
			rx_out <= 1'b1;
		end else begin
			bus.halted_n <= !halt_req;
			bus.page <= page_sel;
			bus.tx <= tx_in;
			rx_out <= rx_s;
		end
	end

	assign irq_level = !irq_s;
	assign fast_irq = family == bmb_pkg::FAM_ALT && !firq_s;

	// a new falling edge in the acknowledge cycle keeps the request
	always_ff @(posedge clk) begin
		if (rst) begin
			nmi_prev_reg <= 1'b1;
			nmi_pending <= 1'b0;
		end else begin
			nmi_prev_reg <= nmi_s;
			nmi_pending <= (nmi_prev_reg && !nmi_s) || (nmi_pending && !nmi_ack);
		end
	end

endmodule // bmb_proc_end

`default_nettype wire

// file: common/bmb_cfg.svh
// constants for the backplane module bus: widths, decode and timing counts
// assumes a single 50 MHz design clock shared by both ends
`ifndef BMB_CFG_SVH
`define BMB_CFG_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define BMB_ADDR_W 24
`define BMB_DATA_W 16
`define BMB_CTL_W 4
`define BMB_PSYNC_W 24
`define BMB_MSYNC_W 50

// ---------------------------------------------------------------
// field positions of the shared strobe vector
// ---------------------------------------------------------------
`define BMB_CTL_MEM 3
`define BMB_CTL_IO 2
`define BMB_CTL_RD 1
`define BMB_CTL_WR 0

// ---------------------------------------------------------------
// address map
// ---------------------------------------------------------------
`define BMB_ROM_BASE 24'h000000
`define BMB_ROM_LIMIT 24'h002000
`define BMB_LOW_BYTE_MSB 7
`define BMB_WORD16_MSB 15

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define BMB_SYS_CLK_KHZ 50000
`define BMB_LEGACY_BUS_CLK_HZ 7372800
`define BMB_STROBE_NS 240
`define BMB_STROBE_CYC ((`BMB_STROBE_NS * `BMB_SYS_CLK_KHZ + 999999) / 1000000)
`define BMB_CNT_W 4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define BMB_IDLE_CTL 4'hF

`endif

// file: common/bmb_pkg.sv
// types shared by both ends of the backplane module bus
// assumes bmb_cfg.svh for numeric constants
package bmb_pkg;

	typedef enum logic [1:0] {
		FAM_STD,
		FAM_ALT,
		FAM_SIO
	} bmb_family_t;

	typedef enum logic [1:0] {
		PROF_MINIMAL,
		PROF_40,
		PROF_ENH,
		PROF_80
	} bmb_profile_t;

	typedef enum logic [2:0] {
		CMD_MEM_RD,
		CMD_MEM_WR,
		CMD_IO_RD,
		CMD_IO_WR,
		CMD_REFRESH,
		CMD_SIO
	} bmb_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_STROBE,
		ST_WAIT,
		ST_DONE,
		ST_RELEASE,
		ST_GRANT
	} bmb_state_t;

endpackage

// file: common/bmb_bus_if.sv
// backplane wires between the processor end and one module end
// resolves each tristate or open-drain line from the drivers' enables; idle lines pull high
`timescale 1ns/100ps
`default_nettype none
`include "bmb_cfg.svh"

interface bmb_bus_if;
	logic [`BMB_ADDR_W-1:0] p_addr;
	logic [`BMB_ADDR_W-1:0] p_addr_oe_n;
	logic [`BMB_ADDR_W-1:0] m_addr;
	logic m_addr_oe_n;
	logic [`BMB_ADDR_W-1:0] addr;
	logic [`BMB_DATA_W-1:0] p_data;
	logic [1:0] p_data_oe_n;
	logic [`BMB_DATA_W-1:0] m_data;
	logic [1:0] m_data_oe_n;
	logic [`BMB_DATA_W-1:0] data;
	logic [`BMB_CTL_W-1:0] p_ctl_n;
	logic p_ctl_oe_n;
	logic [`BMB_CTL_W-1:0] m_ctl_n;
	logic m_ctl_oe_n;
	logic memory_cycle_n;
	logic io_cycle_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic p_fetch_n;
	logic p_fetch_oe_n;
	logic opcode_fetch_cycle_n;
	logic refresh_cycle_n;
	logic bus_grant_n;
	logic halted_n;
	logic page;
	logic m_busrq_oe_n;
	logic master_request_n;
	logic m_irq_oe_n;
	logic shared_irq_n;
	logic m_nmi_oe_n;
	logic unmaskable_irq_n;
	logic m_firq_oe_n;
	logic fast_irq_n;
	logic m_wait_oe_n;
	logic not_ready_n;
	logic dma_grant_in_n;
	logic dma_grant_out_n;
	logic irq_chain_in;
	logic irq_chain_out;
	logic tx;
	logic rx;
	logic read_write;
	logic data_enable;
	logic memory_enable_n;
	logic serial_io_clock_n;
	logic serial_io_in;

	// ---------------------------------------------------------------
	// wire resolution
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < `BMB_ADDR_W; i++) begin
			addr[i] = !p_addr_oe_n[i] ? p_addr[i] : (!m_addr_oe_n ? m_addr[i] : 1'b1);
		end
		for (int i = 0; i < `BMB_DATA_W; i++) begin
			data[i] = !p_data_oe_n[i/8] ? p_data[i] : (!m_data_oe_n[i/8] ? m_data[i] : 1'b1);
		end
	end

	assign {memory_cycle_n, io_cycle_n, read_strobe_n, write_strobe_n} =
		!p_ctl_oe_n ? p_ctl_n : (!m_ctl_oe_n ? m_ctl_n : `BMB_IDLE_CTL);
	assign opcode_fetch_cycle_n = p_fetch_oe_n | p_fetch_n;
	assign master_request_n = m_busrq_oe_n;
	assign shared_irq_n = m_irq_oe_n;
	assign unmaskable_irq_n = m_nmi_oe_n;
	assign fast_irq_n = m_firq_oe_n;
	assign not_ready_n = m_wait_oe_n;
	// chain heads: grant enters from the processor, irq chain starts enabled
	assign dma_grant_in_n = bus_grant_n;
	assign irq_chain_in = 1'b1;

	modport proc (
		output p_addr, p_addr_oe_n, p_data, p_data_oe_n, p_ctl_n, p_ctl_oe_n,
		output p_fetch_n, p_fetch_oe_n, refresh_cycle_n, bus_grant_n, halted_n, page,
		output tx, read_write, memory_enable_n, serial_io_clock_n,
		input data, master_request_n, shared_irq_n, unmaskable_irq_n, fast_irq_n,
		input not_ready_n, rx, data_enable, serial_io_in
	);

	modport mod (
		output m_addr, m_addr_oe_n, m_data, m_data_oe_n, m_ctl_n, m_ctl_oe_n,
		output m_busrq_oe_n, m_irq_oe_n, m_nmi_oe_n, m_firq_oe_n, m_wait_oe_n,
		output dma_grant_out_n, irq_chain_out, rx, data_enable, serial_io_in,
		input addr, data, memory_cycle_n, io_cycle_n, read_strobe_n, write_strobe_n,
		input refresh_cycle_n, bus_grant_n, dma_grant_in_n, irq_chain_in, tx, page
	);
endinterface

`default_nettype wire

// file: verilog/bmb_module_end.sv
// module end of the backplane module bus: memory/io slave, bus master, chain member
// assumes the processor end's strobe window covers this end's filter latency
`timescale 1ns/100ps
`default_nettype none
`include "bmb_cfg.svh"

module bmb_module_end (
	input wire logic clk,
	input wire logic rst,
	bmb_bus_if.mod bus,
	input wire logic [`BMB_LOW_BYTE_MSB:0] io_base,
	input wire logic slave_not_ready,
	input wire logic [`BMB_DATA_W-1:0] slave_rdata,
	output logic slave_req,
	output logic slave_write,
	output logic slave_is_io,
	output logic [`BMB_ADDR_W-1:0] slave_addr,
	output logic [`BMB_DATA_W-1:0] slave_wdata,
	output logic rom_select,
	output logic ram_select,
	input wire logic master_req,
	output logic master_granted,
	input wire logic [`BMB_ADDR_W-1:0] master_addr,
	input wire logic [`BMB_DATA_W-1:0] master_wdata,
	input wire logic [`BMB_CTL_W-1:0] master_ctl,
	input wire logic dma_req,
	input wire logic irq_req,
	output logic irq_priority_ok,
	input wire logic nmi_req,
	input wire logic firq_req,
	input wire logic de_in,
	input wire logic sio_bit,
	input wire logic rx_in,
	output logic tx_out
);

	// ---------------------------------------------------------------
	// input filter
	// ---------------------------------------------------------------
	logic [`BMB_MSYNC_W-1:0] sync1_reg;
	logic [`BMB_MSYNC_W-1:0] sync2_reg;
	logic [`BMB_MSYNC_W-1:0] sync3_reg;
	logic [`BMB_MSYNC_W-1:0] in_reg;
	logic mem_s, io_s, rd_s, wr_s, rfsh_s, grant_s, dgi_s, chain_s, tx_s, page_s;
	logic [`BMB_ADDR_W-1:0] addr_s;
	logic [`BMB_DATA_W-1:0] data_s;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			sync3_reg <= '1;
			in_reg <= '1;
		end else begin
			sync1_reg <= {bus.memory_cycle_n, bus.io_cycle_n, bus.read_strobe_n,
				bus.write_strobe_n, bus.refresh_cycle_n, bus.bus_grant_n,
				bus.dma_grant_in_n, bus.irq_chain_in, bus.tx, bus.page, bus.addr, bus.data};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			in_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (in_reg & (sync2_reg ^ sync3_reg));
		end
	end

	assign {mem_s, io_s, rd_s, wr_s, rfsh_s, grant_s, dgi_s, chain_s, tx_s, page_s,
		addr_s, data_s} = in_reg;

	// ---------------------------------------------------------------
	// slave decode
	// ---------------------------------------------------------------
	logic mem_hit, io_hit, hit, hit_prev_reg, rd_hit;

	// refresh cycles carry a memory cycle but no transfer
	assign mem_hit = !mem_s && rfsh_s && (!rd_s || !wr_s);
	assign io_hit = !io_s && addr_s[`BMB_LOW_BYTE_MSB:0] == io_base && (!rd_s || !wr_s);
	assign hit = (mem_hit || io_hit) && !master_granted;
	assign rd_hit = hit && !rd_s;
	assign rom_select = mem_hit && !page_s && addr_s < `BMB_ROM_LIMIT
		&& addr_s >= `BMB_ROM_BASE;
	assign ram_select = mem_hit && !rom_select;

	always_ff @(posedge clk) begin
		if (rst) begin
			hit_prev_reg <= 1'b0;
			slave_req <= 1'b0;
			slave_write <= 1'b0;
			slave_is_io <= 1'b0;
			slave_addr <= '0;
			slave_wdata <= '0;
		end else begin
			hit_prev_reg <= hit;
			slave_req <= hit && !hit_prev_reg;
			if (hit && !hit_prev_reg) begin
				slave_write <= !wr_s;
				slave_is_io <= io_hit;
				slave_addr <= addr_s;
				slave_wdata <= data_s;
			end
		end
	end

	assign bus.m_wait_oe_n = !(hit && slave_not_ready);

	// ---------------------------------------------------------------
	// bus master
	// ---------------------------------------------------------------
	logic rq_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			rq_reg <= 1'b0;
		end else begin
			rq_reg <= master_req;
		end
	end

	assign bus.m_busrq_oe_n = !rq_reg;
	assign master_granted = rq_reg && !grant_s;
	assign bus.m_addr = master_addr;
	assign bus.m_addr_oe_n = !master_granted;
	assign bus.m_ctl_n = ~master_ctl;
	assign bus.m_ctl_oe_n = !master_granted;

	// the slave's read data leaves through the same lanes when not mastering
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.m_data <= '0;
		end else begin
			bus.m_data <= master_granted ? master_wdata : slave_rdata;
		end
	end

	assign bus.m_data_oe_n[0] = !((master_granted && master_ctl[`BMB_CTL_WR]) || rd_hit);
	assign bus.m_data_oe_n[1] = !((master_granted && master_ctl[`BMB_CTL_WR]) || rd_hit);

	// ---------------------------------------------------------------
	// chains, interrupts and side lines
	// ---------------------------------------------------------------
	assign bus.dma_grant_out_n = dgi_s || dma_req;
	assign irq_priority_ok = chain_s;
	assign bus.irq_chain_out = chain_s && !irq_req;
	assign bus.m_irq_oe_n = !irq_req;
	assign bus.m_nmi_oe_n = !nmi_req;
	assign bus.m_firq_oe_n = !firq_req;

	always_ff @(posedge clk) begin
		if (rst) begin
			bus.data_enable <= 1'b1;
			bus.serial_io_in <= 1'b0;
			bus.rx <= 1'b1;
			tx_out <= 1'b1;
		end else begin
			bus.data_enable <= de_in;
			bus.serial_io_in <= sio_bit;
			bus.rx <= rx_in;
			tx_out <= tx_s;
		end
	end

endmodule // bmb_module_end

`default_nettype wire

// file: test/bmb_bus_assertions.sv
// checker for the backplane wires between the processor end and one module end
// assumes the bench instantiates it beside the bus interface, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "bmb_cfg.svh"

module bmb_bus_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`BMB_ADDR_W-1:0] p_addr_oe_n,
	input wire logic [1:0] p_data_oe_n,
	input wire logic p_ctl_oe_n,
	input wire logic [`BMB_ADDR_W-1:0] addr,
	input wire logic memory_cycle_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic opcode_fetch_cycle_n,
	input wire logic refresh_cycle_n,
	input wire logic bus_grant_n,
	input wire logic master_request_n,
	input wire logic not_ready_n,
	input wire logic m_irq_oe_n,
	input wire logic irq_chain_out,
	input wire logic dma_grant_in_n,
	input wire logic dma_grant_out_n
);
	// ---------------------------------
	// ownership, strobes and chains
	// ---------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	release_first_a: assert property (!bus_grant_n |->
		p_ctl_oe_n && (&p_data_oe_n) && (&p_addr_oe_n)) else $error("grant while bus driven");
	grant_needs_request_a: assert property (master_request_n [*6] |-> bus_grant_n)
		else $error("grant without request");
	strobes_apart_a: assert property (!(!read_strobe_n && !write_strobe_n))
		else $error("read and write strobes together");
	strobe_width_a: assert property ($fell(read_strobe_n) && !p_ctl_oe_n |->
		!read_strobe_n [*8]) else $error("read strobe too short");
	addr_held_a: assert property (!memory_cycle_n && !$past(memory_cycle_n) |-> $stable(addr))
		else $error("address moved in memory cycle");
	refresh_form_a: assert property (!refresh_cycle_n |->
		!memory_cycle_n && read_strobe_n && write_strobe_n) else $error("bad refresh cycle");
	fetch_in_mem_a: assert property (!opcode_fetch_cycle_n |-> !memory_cycle_n)
		else $error("fetch line outside memory cycle");
	wait_holds_a: assert property ((!not_ready_n && !p_ctl_oe_n) [*4] ##0 !write_strobe_n
		|=> !write_strobe_n) else $error("strobe ended during wait");
	irq_chain_block_a: assert property (!m_irq_oe_n [*4] |-> !irq_chain_out)
		else $error("chain passed while requesting");
	dma_chain_pass_a: assert property (dma_grant_in_n [*5] |-> dma_grant_out_n)
		else $error("dma grant passed without grant in");
endmodule // bmb_bus_assertions

`default_nettype wire

// file: test/backplane_module_bus_interface_bench.sv
// bench joining the processor end and a module end through the bus interface
// assumes one 50 MHz clock and synchronous active-high reset for both ends
`timescale 1ns/100ps
`default_nettype none
`include "bmb_cfg.svh"

module backplane_module_bus_interface_bench;
	logic clk, rst, wide_addr, has_fetch_indicator, page_sel, halt_req, cmd_valid, cmd_ready;
	logic cmd_fetch, cmd_wide, rsp_valid, bus_released, irq_level, fast_irq, nmi_pending, nmi_ack;
	logic tx_in, rx_out, slave_not_ready, slave_req, slave_write, slave_is_io, rom_select;
	logic ram_select, master_req, master_granted, dma_req, irq_req, irq_priority_ok, nmi_req;
	logic firq_req, de_in, sio_bit, rx_in, tx_out, got_wr, got_io, got_rom, got_ram;
	logic [3:0] master_ctl;
	logic [7:0] io_base;
	logic [15:0] cmd_wdata, rsp_rdata, slave_rdata, slave_wdata, master_wdata, got_data;
	logic [23:0] cmd_addr, slave_addr, master_addr, got_addr;
	bmb_pkg::bmb_family_t family;
	bmb_pkg::bmb_profile_t profile;
	bmb_pkg::bmb_cmd_t cmd_kind;
	int err_count, num_checks, lat;

	bmb_bus_if bmb_bus_if_i();
	bmb_proc_end bmb_proc_end_i(.bus(bmb_bus_if_i), .*);
	bmb_module_end bmb_module_end_i(.bus(bmb_bus_if_i), .*);
	bmb_bus_assertions bmb_bus_assertions_i(.clk(clk), .rst(rst),
		.p_addr_oe_n(bmb_bus_if_i.p_addr_oe_n), .p_data_oe_n(bmb_bus_if_i.p_data_oe_n),
		.p_ctl_oe_n(bmb_bus_if_i.p_ctl_oe_n), .addr(bmb_bus_if_i.addr),
		.memory_cycle_n(bmb_bus_if_i.memory_cycle_n), .read_strobe_n(bmb_bus_if_i.read_strobe_n),
		.write_strobe_n(bmb_bus_if_i.write_strobe_n),
		.opcode_fetch_cycle_n(bmb_bus_if_i.opcode_fetch_cycle_n),
		.refresh_cycle_n(bmb_bus_if_i.refresh_cycle_n), .bus_grant_n(bmb_bus_if_i.bus_grant_n),
		.master_request_n(bmb_bus_if_i.master_request_n), .not_ready_n(bmb_bus_if_i.not_ready_n),
		.m_irq_oe_n(bmb_bus_if_i.m_irq_oe_n), .irq_chain_out(bmb_bus_if_i.irq_chain_out),
		.dma_grant_in_n(bmb_bus_if_i.dma_grant_in_n),
		.dma_grant_out_n(bmb_bus_if_i.dma_grant_out_n));

	// ---------------------------------
	// helpers
	// ---------------------------------
	// slave strobes are pulses, so keep what the last hit carried
	always @(posedge clk) begin
		if (slave_req === 1'h1) begin
			got_addr <= slave_addr;
			got_data <= slave_wdata;
			got_wr <= slave_write;
			got_io <= slave_is_io;
			got_rom <= rom_select;
			got_ram <= ram_select;
		end
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmd(input bmb_pkg::bmb_cmd_t k, input logic [23:0] a, input logic [15:0] d);
		cmd_kind = k;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'h1;
		for (lat = 0; lat < 99 && cmd_ready !== 1'h1; lat++)
			wt(1);
		wt(1);
		cmd_valid = 1'h0;
		for (lat = 1; lat < 400 && rsp_valid !== 1'h1; lat++)
			wt(1);
		chk("answer", 1'h1, rsp_valid);
	endtask

	// ---------------------------------
	// scenarios
	// ---------------------------------
	task automatic t_mem;
		cmd(bmb_pkg::CMD_MEM_WR, 24'h000010, 16'h00A5);
		chk("wr addr", 24'h000010, got_addr);
		chk("wr flag", 1'h1, got_wr);
		chk("wr data", 8'hA5, got_data[7:0]);
		chk("rom low", 1'h1, got_rom);
		cmd_fetch = 1'h1;
		cmd(bmb_pkg::CMD_MEM_RD, 24'h001FFF, 16'h0000);
		cmd_fetch = 1'h0;
		chk("rd flag", 1'h0, got_wr);
		chk("rd narrow", 16'h0034, rsp_rdata);
		chk("rom top", 1'h1, got_rom);
	endtask

	task automatic t_page;
		page_sel = 1'h1;
		cmd_wide = 1'h1;
		wt(6);
		cmd(bmb_pkg::CMD_MEM_RD, 24'h000000, 16'h0000);
		chk("ram sel", 1'h1, got_ram);
		chk("rom off", 1'h0, got_rom);
		chk("rd wide", 16'h1234, rsp_rdata);
		cmd(bmb_pkg::CMD_REFRESH, 24'h000055, 16'h0000);
		cmd_wide = 1'h0;
		page_sel = 1'h0;
	endtask

	task automatic t_wait;
		slave_not_ready = 1'h1;
		fork
			cmd(bmb_pkg::CMD_IO_WR, 24'h000040, 16'h00C3);
			begin
				wt(40);
				slave_not_ready = 1'h0;
			end
		join
		chk("io flag", 1'h1, got_io);
		chk("io data", 8'hC3, got_data[7:0]);
		chk("stretched", 1'h1, lat > 38);
	endtask

	task automatic t_master;
		master_req = 1'h1;
		for (int i = 0; i < 30 && master_granted !== 1'h1; i++)
			wt(1);
		chk("granted", 1'h1, master_granted);
		chk("released", 1'h1, bus_released);
		chk("dma pass", 1'h0, bmb_bus_if_i.dma_grant_out_n);
		dma_req = 1'h1;
		wt(6);
		chk("dma held", 1'h1, bmb_bus_if_i.dma_grant_out_n);
		dma_req = 1'h0;
		master_req = 1'h0;
		wt(12);
		chk("returned", 1'h0, bus_released);
	endtask

	task automatic t_irq;
		irq_req = 1'h1;
		nmi_req = 1'h1;
		firq_req = 1'h1;
		family = bmb_pkg::FAM_ALT;
		wt(6);
		chk("irq seen", 1'h1, irq_level);
		chk("chain cut", 1'h0, bmb_bus_if_i.irq_chain_out);
		chk("chain ok", 1'h1, irq_priority_ok);
		chk("nmi edge", 1'h1, nmi_pending);
		chk("fast irq", 1'h1, fast_irq);
		irq_req = 1'h0;
		firq_req = 1'h0;
		family = bmb_pkg::FAM_STD;
		nmi_ack = 1'h1;
		wt(1);
		nmi_ack = 1'h0;
		wt(6);
		chk("chain on", 1'h1, bmb_bus_if_i.irq_chain_out);
		chk("irq gone", 1'h0, irq_level);
		chk("nmi level", 1'h0, nmi_pending);
		nmi_req = 1'h0;
	endtask

	task automatic t_serial;
		tx_in = 1'h0;
		rx_in = 1'h0;
		halt_req = 1'h1;
		wt(8);
		chk("tx low", 1'h0, tx_out);
		chk("rx low", 1'h0, rx_out);
		chk("halted", 1'h0, bmb_bus_if_i.halted_n);
		tx_in = 1'h1;
		rx_in = 1'h1;
		halt_req = 1'h0;
		wt(8);
		chk("tx high", 1'h1, tx_out);
		chk("rx high", 1'h1, rx_out);
	endtask

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	initial begin
		{rst, wide_addr, has_fetch_indicator, de_in, tx_in, rx_in} = 6'h3F;
		{page_sel, halt_req, cmd_valid, cmd_fetch, cmd_wide, nmi_ack, slave_not_ready} = '0;
		{master_req, dma_req, irq_req, nmi_req, firq_req, sio_bit, master_ctl} = '0;
		{cmd_addr, cmd_wdata, master_addr, master_wdata} = '0;
		{err_count, num_checks} = '0;
		io_base = 8'h40;
		slave_rdata = 16'h1234;
		family = bmb_pkg::FAM_STD;
		profile = bmb_pkg::PROF_80;
		cmd_kind = bmb_pkg::CMD_MEM_RD;
		repeat (20) @(posedge clk);
		#1 rst = 1'h0;
		wt(2);
		t_mem();
		t_page();
		t_wait();
		t_master();
		t_irq();
		t_serial();
		stop_test();
	end

	// whole run needs well under a thousand cycles
	initial begin
		#(20 * 3000);
		err_count++;
		stop_test();
	end
endmodule // backplane_module_bus_interface_bench

`default_nettype wire
